// file: rtl/mhf_datapath.sv
// module: host fifo data path with ahb-lite register slave
//
// Overview of operation
// RULE_01: host halts transmitter via halt request bit
// RULE_02: frame in flight finishes before stopping
// RULE_03: after final status clear bits, pulse halted
// RULE_04: setting run resumes pending transmit data
// RULE_05: frame bytes stored first, pointer advancing
// RULE_06: status word pushed last, separate fifo
// RULE_07: level register shows data and status counts
// RULE_08: status words readable before any data
// RULE_09: over-read raises fault flag; soft reset
// RULE_10: programmable start offset 0-31 bytes
// RULE_11: host changes offset only between packets
// RULE_12: optional end padding to burst multiple
// RULE_13: host drops padding using status length
// RULE_14: offset and padding applied per packet
// RULE_15: host reads status, then exact word count
// RULE_16: skip bit discards head packet data
// RULE_17: skip only for packets of 4+ words
// RULE_18: skip bit self-clears; no data reads meanwhile
// RULE_19: skip leaves status fifo untouched
// RULE_20: skip works while receiver runs
// RULE_21: flush resets both fifo pointers, self-clears
// RULE_22: host flushes only after receiver halted
// RULE_23: clearing run halts receiver, pulses halted
// RULE_24: status fifo overflow raises fault flag
// RULE_25: soft reset empties fifos, clears skip/flush
`timescale 1ns/1ps
module mhf_datapath (
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic              hsel_i,
  input  wire logic [31:0]       haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic      [31:0]       hrdata_o,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  input  wire mhf_pkg::mhf_line_s line_side_mac_i,
  output logic                   line_side_mac_ready_o,
  input  wire logic              tx_frame_busy_i,
  input  wire logic              tx_status_done_i,
  output logic                   tx_run_o,
  output logic                   transmit_halted_pulse_o,
  output logic                   receive_run_o,
  output logic                   receive_halted_pulse_o,
  output logic                   receive_fault_flag_o
);
  // ****************************************
  // storage and state
  // ****************************************
  logic [7:0]         dmem [256];
  logic [31:0]        smem [16];
  logic [8:0]         bmem [16];
  mhf_pkg::mhf_wst_e  st_r,  st_nxt;
  logic [8:0]         wr_r,  wr_nxt;
  logic [4:0]         swr_r, swr_nxt;
  logic [4:0]         bwr_r, bwr_nxt;
  logic [4:0]         cnt_r, cnt_nxt;
  logic [5:0]         pos_r, pos_nxt;
  logic [5:0]         lim_r, lim_nxt;
  logic [31:0]        sh_r,  sh_nxt;
  logic               rdy_r, rdy_nxt;
  logic               ovf_r, ovf_nxt;
  logic               dwe;
  logic [7:0]         dwd;
  logic               swe;
  logic               bwe;
  logic [8:0]         rd_r,  rd_nxt;
  logic [4:0]         srd_r, srd_nxt;
  logic [4:0]         brd_r, brd_nxt;
  mhf_pkg::mhf_aph_s  aph_r, aph_nxt;
  logic [31:0]        hrd_r, hrd_nxt;
  logic [4:0]         ofs_r, ofs_nxt;
  logic [3:0]         bst_r, bst_nxt;
  logic               pad_r, pad_nxt;
  logic               fls_r, fls_nxt;
  logic               skp_r, skp_nxt;
  logic               run_r, run_nxt;
  logic               txr_r, txr_nxt;
  logic               txh_r, txh_nxt;
  logic               flt_r, flt_nxt;
  logic               rst_r, rst_nxt;
  logic               txp_r, txp_nxt;
  logic               rxp_r, rxp_nxt;
  logic               srs_r, srs_nxt;
  logic               hrdy_r;
  logic               hrsp_r;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [8:0] used(input logic [8:0] w, input logic [8:0] r);
    used = w - r;
  endfunction : used

  function automatic logic [5:0] step(input logic [5:0] p, input logic [5:0] l);
    step = (p == l) ? 6'h00 : p + 6'h01;
  endfunction : step

  // ****************************************
  // line side write path
  // ****************************************
  always_comb begin
    st_nxt  = st_r;
    wr_nxt  = wr_r;
    swr_nxt = swr_r;
    bwr_nxt = bwr_r;
    cnt_nxt = cnt_r;
    pos_nxt = pos_r;
    lim_nxt = lim_r;
    sh_nxt  = sh_r;
    ovf_nxt = 1'b0;
    dwe     = 1'b0;
    dwd     = 8'h00;
    swe     = 1'b0;
    bwe     = 1'b0;
    case (st_r)
      mhf_pkg::ST_IDLE: begin
        if (run_r && line_side_mac_i.valid) begin
          cnt_nxt = ofs_r; // RULE_10 RULE_14
          lim_nxt = pad_r ? {bst_r, 2'b11} : 6'h03; // RULE_12
          pos_nxt = 6'h00;
          st_nxt  = mhf_pkg::ST_OFS;
        end
      end
      mhf_pkg::ST_OFS: begin
        if (cnt_r == 5'h00) begin
          st_nxt = mhf_pkg::ST_DATA;
        end else if (used(wr_r, rd_r) <= mhf_pkg::DFULL_GUARD) begin
          dwe     = 1'b1; // RULE_10
          cnt_nxt = cnt_r - 5'h01;
          pos_nxt = step(pos_r, lim_r);
        end
      end
      mhf_pkg::ST_DATA: begin
        if (line_side_mac_i.valid && rdy_r) begin
          dwe     = 1'b1; // RULE_05
          dwd     = line_side_mac_i.data;
          pos_nxt = step(pos_r, lim_r);
          if (line_side_mac_i.last) begin
            sh_nxt = line_side_mac_i.status;
            st_nxt = mhf_pkg::ST_PAD;
          end
        end
      end
      mhf_pkg::ST_PAD: begin
        if (pos_r == 6'h00) begin
          st_nxt = mhf_pkg::ST_STAT;
        end else if (used(wr_r, rd_r) <= mhf_pkg::DFULL_GUARD) begin
          dwe     = 1'b1; // RULE_12 RULE_14
          pos_nxt = step(pos_r, lim_r);
        end
      end
      mhf_pkg::ST_STAT: begin
        if ((swr_r - srd_r) == 5'h10) begin
          ovf_nxt = 1'b1; // RULE_24
        end else begin
          swe     = 1'b1; // RULE_06
          swr_nxt = swr_r + 5'h01;
        end
        if ((bwr_r - brd_r) != 5'h10) begin
          bwe     = 1'b1;
          bwr_nxt = bwr_r + 5'h01;
        end
        st_nxt = mhf_pkg::ST_IDLE;
      end
      default: st_nxt = mhf_pkg::ST_IDLE;
    endcase
    if (dwe) begin
      wr_nxt = wr_r + 9'h001; // RULE_05
    end
    if (fls_r || srs_r) begin
      st_nxt  = mhf_pkg::ST_IDLE; // RULE_21 RULE_25
      wr_nxt  = 9'h000;
      swr_nxt = 5'h00;
      bwr_nxt = 5'h00;
    end
    rdy_nxt = (st_nxt == mhf_pkg::ST_DATA) && (used(wr_nxt, rd_r) < mhf_pkg::DFULL_GUARD);
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_r  <= mhf_pkg::ST_IDLE;
      lim_r <= 6'h03;
      {wr_r, swr_r, bwr_r, cnt_r, pos_r, sh_r, rdy_r, ovf_r} <= '0;
    end else begin
      st_r  <= st_nxt;
      {wr_r, swr_r, bwr_r, cnt_r, pos_r, lim_r} <= {wr_nxt, swr_nxt, bwr_nxt, cnt_nxt, pos_nxt, lim_nxt};
      {sh_r, rdy_r, ovf_r} <= {sh_nxt, rdy_nxt, ovf_nxt};
    end
  end

  always_ff @(posedge clock_i) begin
    if (dwe) begin
      dmem[wr_r[7:0]] <= dwd;
    end
    if (swe) begin
      smem[swr_r[3:0]] <= sh_r;
    end
    if (bwe) begin
      bmem[bwr_r[3:0]] <= wr_r;
    end
  end

  // ****************************************
  // bus slave, registers and read path
  // ****************************************
  always_comb begin
    aph_nxt = '0;
    hrd_nxt = hrd_r;
    rd_nxt  = rd_r;
    srd_nxt = srd_r;
    brd_nxt = brd_r;
    ofs_nxt = ofs_r;
    bst_nxt = bst_r;
    pad_nxt = pad_r;
    fls_nxt = fls_r;
    skp_nxt = skp_r;
    run_nxt = run_r;
    txr_nxt = txr_r;
    txh_nxt = txh_r;
    flt_nxt = flt_r;
    rst_nxt = rst_r;
    srs_nxt = 1'b0;
    txp_nxt = 1'b0;
    rxp_nxt = 1'b0;
    if (aph_r.wr) begin
      case (aph_r.addr)
        mhf_pkg::A_RXCFG: begin
          ofs_nxt = hwdata_i[mhf_pkg::OFS_LSB +: 5];
          bst_nxt = hwdata_i[mhf_pkg::BURST_LSB +: 4];
          pad_nxt = hwdata_i[mhf_pkg::PAD_BIT];
          fls_nxt = hwdata_i[mhf_pkg::FLUSH_BIT] | fls_r;
        end
        mhf_pkg::A_PATH:   skp_nxt = hwdata_i[mhf_pkg::SKIP_BIT] | skp_r;
        mhf_pkg::A_MACCTL: run_nxt = hwdata_i[mhf_pkg::RUN_BIT];
        mhf_pkg::A_TXCFG: begin
          txr_nxt = hwdata_i[mhf_pkg::TXRUN_BIT] | txr_r; // RULE_04
          txh_nxt = hwdata_i[mhf_pkg::TXHLT_BIT] | txh_r;
        end
        mhf_pkg::A_EVENT: flt_nxt = flt_r & ~hwdata_i[mhf_pkg::FAULT_BIT];
        mhf_pkg::A_SRST:  srs_nxt = hwdata_i[mhf_pkg::SRST_BIT];
        default: ;
      endcase
    end
    if (hsel_i && htrans_i[1] && hready_i) begin
      aph_nxt = '{wr: hwrite_i, addr: haddr_i[7:0]};
      hrd_nxt = 32'h00000000;
      if (!hwrite_i) begin
        case (haddr_i[7:0])
          mhf_pkg::A_RXDATA: begin
            if (used(wr_r, rd_r) < mhf_pkg::WORD_BYTES) begin
              flt_nxt = 1'b1; // RULE_09
            end else begin
              hrd_nxt = {dmem[8'(rd_r + 9'h003)], dmem[8'(rd_r + 9'h002)],
                         dmem[8'(rd_r + 9'h001)], dmem[rd_r[7:0]]};
              rd_nxt  = rd_r + mhf_pkg::WORD_BYTES;
              if ((brd_r != bwr_r) && (rd_nxt == bmem[brd_r[3:0]])) begin
                brd_nxt = brd_r + 5'h01; // RULE_14
              end
            end
          end
          mhf_pkg::A_RXSTAT: begin
            if (srd_r == swr_r) begin
              flt_nxt = 1'b1; // RULE_09
            end else begin
              hrd_nxt = smem[srd_r[3:0]]; // RULE_08
              srd_nxt = srd_r + 5'h01;
            end
          end
          mhf_pkg::A_INFO: begin
            hrd_nxt[mhf_pkg::SCNT_LSB +: 5] = swr_r - srd_r; // RULE_07
            hrd_nxt[8:0] = used(wr_r, rd_r);
          end
          mhf_pkg::A_RXCFG: begin
            hrd_nxt[mhf_pkg::OFS_LSB +: 5]   = ofs_r;
            hrd_nxt[mhf_pkg::BURST_LSB +: 4] = bst_r;
            hrd_nxt[mhf_pkg::PAD_BIT]        = pad_r;
            hrd_nxt[mhf_pkg::FLUSH_BIT]      = fls_r;
          end
          mhf_pkg::A_PATH:   hrd_nxt[mhf_pkg::SKIP_BIT] = skp_r;
          mhf_pkg::A_MACCTL: hrd_nxt[mhf_pkg::RUN_BIT] = run_r;
          mhf_pkg::A_TXCFG: begin
            hrd_nxt[mhf_pkg::TXRUN_BIT] = txr_r;
            hrd_nxt[mhf_pkg::TXHLT_BIT] = txh_r;
          end
          mhf_pkg::A_EVENT: begin
            hrd_nxt[mhf_pkg::FAULT_BIT] = flt_r;
            hrd_nxt[mhf_pkg::RHLT_BIT]  = rst_r;
          end
          default: ;
        endcase
      end
    end
    if (skp_r && (brd_r != bwr_r)) begin
      rd_nxt  = bmem[brd_r[3:0]]; // RULE_16 RULE_19 RULE_20
      brd_nxt = brd_r + 5'h01;
      skp_nxt = 1'b0; // RULE_18
    end
    if (ovf_r) begin
      flt_nxt = 1'b1; // RULE_24
    end
    if (txh_r && txr_r && (tx_status_done_i || !tx_frame_busy_i)) begin
      txr_nxt = 1'b0; // RULE_02 RULE_03
      txh_nxt = 1'b0;
      txp_nxt = 1'b1;
    end
    if (!run_r && !rst_r && (st_r == mhf_pkg::ST_IDLE)) begin
      rst_nxt = 1'b1; // RULE_23
      rxp_nxt = 1'b1;
    end else if (run_r) begin
      rst_nxt = 1'b0;
    end
    if (fls_r || srs_r) begin
      rd_nxt  = 9'h000; // RULE_21
      srd_nxt = 5'h00;
      brd_nxt = 5'h00;
      fls_nxt = 1'b0;
    end
    if (srs_r) begin
      skp_nxt = 1'b0; // RULE_25
      flt_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ofs_r  <= mhf_pkg::OFS_RST;
      bst_r  <= mhf_pkg::BURST_RST;
      run_r  <= mhf_pkg::RUN_RST;
      hrdy_r <= 1'b1;
      {aph_r, hrd_r, rd_r, srd_r, brd_r, pad_r, fls_r, skp_r} <= '0;
      {txr_r, txh_r, flt_r, rst_r, txp_r, rxp_r, srs_r, hrsp_r} <= '0;
    end else begin
      hrdy_r <= 1'b1;
      hrsp_r <= 1'b0;
      {aph_r, hrd_r, rd_r, srd_r, brd_r} <= {aph_nxt, hrd_nxt, rd_nxt, srd_nxt, brd_nxt};
      {ofs_r, bst_r, pad_r, fls_r, skp_r, run_r} <= {ofs_nxt, bst_nxt, pad_nxt, fls_nxt, skp_nxt, run_nxt};
      {txr_r, txh_r, flt_r, rst_r} <= {txr_nxt, txh_nxt, flt_nxt, rst_nxt};
      {txp_r, rxp_r, srs_r} <= {txp_nxt, rxp_nxt, srs_nxt};
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign hrdata_o                = hrd_r;
  assign hreadyout_o             = hrdy_r;
  assign hresp_o                 = hrsp_r;
  assign line_side_mac_ready_o   = rdy_r;
  assign tx_run_o                = txr_r;
  assign transmit_halted_pulse_o = txp_r;
  assign receive_run_o           = run_r;
  assign receive_halted_pulse_o  = rxp_r;
  assign receive_fault_flag_o    = flt_r;
endmodule : mhf_datapath

// file: rtl/mhf_pkg.sv
// package: constants and types of the host fifo data path
package mhf_pkg;
  // ****************************************
  // sizes
  // ****************************************
  localparam int DAW = 8;
  localparam int SAW = 4;
  localparam logic [DAW:0] DFULL_GUARD = 9'h0FE;
  localparam logic [DAW:0] WORD_BYTES  = 9'h004;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] A_RXDATA = 8'h00;
  localparam logic [7:0] A_RXSTAT = 8'h04;
  localparam logic [7:0] A_INFO   = 8'h08;
  localparam logic [7:0] A_RXCFG  = 8'h0C;
  localparam logic [7:0] A_PATH   = 8'h10;
  localparam logic [7:0] A_MACCTL = 8'h14;
  localparam logic [7:0] A_TXCFG  = 8'h18;
  localparam logic [7:0] A_EVENT  = 8'h1C;
  localparam logic [7:0] A_SRST   = 8'h20;
  // ****************************************
  // field positions
  // ****************************************
  localparam int OFS_LSB   = 0;
  localparam int BURST_LSB = 8;
  localparam int PAD_BIT   = 12;
  localparam int FLUSH_BIT = 15;
  localparam int SKIP_BIT  = 31;
  localparam int RUN_BIT   = 2;
  localparam int TXRUN_BIT = 0;
  localparam int TXHLT_BIT = 1;
  localparam int FAULT_BIT = 0;
  localparam int RHLT_BIT  = 1;
  localparam int SRST_BIT  = 0;
  localparam int SCNT_LSB  = 16;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [4:0] OFS_RST   = 5'h00;
  localparam logic [3:0] BURST_RST = 4'h0;
  localparam logic       RUN_RST   = 1'b0;
  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic        valid;
    logic        last;
    logic [7:0]  data;
    logic [31:0] status;
  } mhf_line_s;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
  } mhf_aph_s;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OFS  = 3'b001,
    ST_DATA = 3'b011,
    ST_PAD  = 3'b010,
    ST_STAT = 3'b110
  } mhf_wst_e;
endpackage : mhf_pkg

// file: sim/mhf_datapath_sva.sv
// checker: port assertions of the host fifo data path
`timescale 1ns/1ps
module mhf_datapath_chk (
  input wire logic               clock_i,
  input wire logic               rst_i,
  input wire logic               hsel_i,
  input wire logic [31:0]        haddr_i,
  input wire logic [1:0]         htrans_i,
  input wire logic               hwrite_i,
  input wire logic               hready_i,
  input wire logic [31:0]        hrdata_o,
  input wire logic               hreadyout_o,
  input wire logic               hresp_o,
  input wire mhf_pkg::mhf_line_s line_side_mac_i,
  input wire logic               line_side_mac_ready_o,
  input wire logic               tx_frame_busy_i,
  input wire logic               tx_status_done_i,
  input wire logic               tx_run_o,
  input wire logic               transmit_halted_pulse_o,
  input wire logic               receive_run_o,
  input wire logic               receive_halted_pulse_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic take;
  logic fin;
  assign take = hsel_i && htrans_i[1] && hready_i;
  assign fin  = line_side_mac_i.valid && line_side_mac_i.last && line_side_mac_ready_o;
  // ****************************************
  // assertions
  // ****************************************
  zero_wait_a: assert property (hreadyout_o && !hresp_o) else $error("bus not ready or not okay");
  rd_hold_a: assert property (!take |=> $stable(hrdata_o)) else $error("read data moved");
  unmapped_a: assert property (take && !hwrite_i && haddr_i[7:0] == 8'h24 |=> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  tx_finish_a: assert property (tx_run_o && tx_frame_busy_i && !tx_status_done_i |=> tx_run_o)
    else $error("transmitter stopped mid frame");
  tx_stop_a: assert property (transmit_halted_pulse_o |-> !tx_run_o && $past(tx_run_o))
    else $error("halt pulse without run clear");
  tx_pulse_a: assert property (transmit_halted_pulse_o |=> !transmit_halted_pulse_o)
    else $error("halt pulse too long");
  rx_pulse_a: assert property (receive_halted_pulse_o |-> !receive_run_o ##1 !receive_halted_pulse_o)
    else $error("receive halt pulse wrong");
  rx_refuse_a: assert property (!receive_run_o && !line_side_mac_ready_o && !line_side_mac_i.valid
    |=> !line_side_mac_ready_o) else $error("packet accepted while halted");
  last_drop_a: assert property (fin |=> !line_side_mac_ready_o [*2])
    else $error("ready stayed after last byte");
  tx_halt_c: cover property (transmit_halted_pulse_o);
  rx_halt_c: cover property (receive_halted_pulse_o);
  pkt_end_c: cover property (fin);
endmodule : mhf_datapath_chk
bind mhf_datapath mhf_datapath_chk u_chk (.clock_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
  .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .line_side_mac_i, .line_side_mac_ready_o, .tx_frame_busy_i,
  .tx_status_done_i, .tx_run_o, .transmit_halted_pulse_o, .receive_run_o, .receive_halted_pulse_o);

// file: sim/mhf_datapath_tb.sv
// testbench: register-level checks of the host fifo data path
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h exp %h", $time, (g), (e)); end end
module mhf_datapath_tb;
  logic               clock_i, rst_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, rdy_n;
  logic [31:0]        haddr_i, hwdata_i, hrdata_o, rd_n;
  logic [1:0]         htrans_i;
  mhf_pkg::mhf_line_s line_side_mac_i;
  logic               line_side_mac_ready_o, tx_frame_busy_i, tx_status_done_i, tx_run_o;
  logic               transmit_halted_pulse_o, receive_run_o, receive_halted_pulse_o, receive_fault_flag_o;
  int                 mismatches, n_compared, n_thp, n_rhp, k;
  mhf_datapath dut (.clock_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i,
    .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .line_side_mac_i, .line_side_mac_ready_o,
    .tx_frame_busy_i, .tx_status_done_i, .tx_run_o, .transmit_halted_pulse_o, .receive_run_o,
    .receive_halted_pulse_o, .receive_fault_flag_o);
  mhf_mac_model mac (.clock_i, .ready_i(line_side_mac_ready_o), .line_o(line_side_mac_i));
  // ****************************************
  // clock, samplers and tasks
  // ****************************************
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always @(negedge clock_i) begin
    rdy_n = hreadyout_o;
    rd_n = hrdata_o;
  end
  always @(posedge clock_i) begin
    if (transmit_halted_pulse_o === 1'b1) n_thp++;
    if (receive_halted_pulse_o === 1'b1) n_rhp++;
  end
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  task automatic edge_wait;
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (rdy_n !== 1'b1 && n < 50);
    if (rdy_n !== 1'b1) begin
      mismatches++;
      summarize();
    end
  endtask : edge_wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i <= {24'h0, a};
    edge_wait();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    edge_wait();
    r = rd_n;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    `CHK(r, e)
  endtask : rchk
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    logic [31:0] r;
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 32'h0, r);
      n++;
    end while ((r & m) !== v && n < 300);
    `CHK(r & m, v)
    if ((r & m) !== v) summarize();
  endtask : poll
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    rst_i = 1'b1;
    hsel_i = 1'b0;
    haddr_i = 32'h0;
    htrans_i = 2'h0;
    hwrite_i = 1'b0;
    hwdata_i = 32'h0;
    tx_frame_busy_i = 1'b0;
    tx_status_done_i = 1'b0;
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    wr(mhf_pkg::A_MACCTL, 32'h4);
    mac.send(8, 8'h01, 32'h00080000);
    poll(mhf_pkg::A_INFO, 32'hFFFFFFFF, 32'h00010008);
    rchk(mhf_pkg::A_RXSTAT, 32'h00080000);
    rchk(mhf_pkg::A_INFO, 32'h00000008);
    rchk(mhf_pkg::A_RXDATA, 32'h04030201);
    rchk(mhf_pkg::A_RXDATA, 32'h08070605);
    $display("test single packet done");
    wr(mhf_pkg::A_RXCFG, 32'h1);
    repeat (2) mac.send(3, 8'hA1, 32'h00030000);
    poll(mhf_pkg::A_INFO, 32'hFFFFFFFF, 32'h00020008);
    for (k = 0; k < 2; k++) begin
      rchk(mhf_pkg::A_RXSTAT, 32'h00030000);
      rchk(mhf_pkg::A_RXDATA, 32'hA3A2A100);
    end
    wr(mhf_pkg::A_RXCFG, 32'h1100);
    mac.send(5, 8'hB0, 32'h00050000);
    poll(mhf_pkg::A_INFO, 32'hFFFFFFFF, 32'h00010008);
    rchk(mhf_pkg::A_RXSTAT, 32'h00050000);
    rchk(mhf_pkg::A_RXDATA, 32'hB3B2B1B0);
    rchk(mhf_pkg::A_RXDATA, 32'h000000B4);
    wr(mhf_pkg::A_RXCFG, 32'h0);
    $display("test offset and padding done");
    rchk(mhf_pkg::A_RXDATA, 32'h0);
    rchk(mhf_pkg::A_EVENT, 32'h1);
    `CHK(receive_fault_flag_o, 1'b1)
    rchk(8'h24, 32'h0);
    wr(mhf_pkg::A_SRST, 32'h1);
    @(posedge clock_i);
    rchk(mhf_pkg::A_EVENT, 32'h0);
    `CHK(receive_fault_flag_o, 1'b0)
    wr(mhf_pkg::A_MACCTL, 32'h4);
    $display("test underrun done");
    mac.send(16, 8'h20, 32'h00100000);
    mac.send(4, 8'h40, 32'h00040000);
    poll(mhf_pkg::A_INFO, 32'hFFFFFFFF, 32'h00020014);
    wr(mhf_pkg::A_PATH, 32'h80000000);
    poll(mhf_pkg::A_PATH, 32'h80000000, 32'h0);
    rchk(mhf_pkg::A_INFO, 32'h00020004);
    rchk(mhf_pkg::A_RXDATA, 32'h43424140);
    rchk(mhf_pkg::A_RXSTAT, 32'h00100000);
    rchk(mhf_pkg::A_RXSTAT, 32'h00040000);
    $display("test skip packet done");
    tx_frame_busy_i <= 1'b1;
    wr(mhf_pkg::A_TXCFG, 32'h1);
    wr(mhf_pkg::A_TXCFG, 32'h3);
    repeat (4) @(posedge clock_i);
    rchk(mhf_pkg::A_TXCFG, 32'h3);
    tx_status_done_i <= 1'b1;
    @(posedge clock_i);
    tx_status_done_i <= 1'b0;
    tx_frame_busy_i <= 1'b0;
    rchk(mhf_pkg::A_TXCFG, 32'h0);
    `CHK(n_thp, 1)
    wr(mhf_pkg::A_TXCFG, 32'h1);
    rchk(mhf_pkg::A_TXCFG, 32'h1);
    `CHK(tx_run_o, 1'b1)
    $display("test transmit halt done");
    mac.send(4, 8'h60, 32'h00040000);
    poll(mhf_pkg::A_INFO, 32'hFFFFFFFF, 32'h00010004);
    k = n_rhp;
    wr(mhf_pkg::A_MACCTL, 32'h0);
    poll(mhf_pkg::A_EVENT, 32'h2, 32'h2);
    `CHK(n_rhp, k + 1)
    wr(mhf_pkg::A_RXCFG, 32'h8000);
    poll(mhf_pkg::A_RXCFG, 32'h8000, 32'h0);
    rchk(mhf_pkg::A_INFO, 32'h0);
    $display("test halt and flush done");
    wr(mhf_pkg::A_MACCTL, 32'h4);
    repeat (17) mac.send(1, 8'h55, 32'h1);
    poll(mhf_pkg::A_EVENT, 32'h1, 32'h1);
    rchk(mhf_pkg::A_INFO, 32'h00100044);
    wr(mhf_pkg::A_SRST, 32'h1);
    @(posedge clock_i);
    rchk(mhf_pkg::A_INFO, 32'h0);
    `CHK(receive_fault_flag_o, 1'b0)
    $display("test overflow done");
    `CHK(mac.stalls, 0)
    summarize();
  end
endmodule : mhf_datapath_tb

// file: sim/mhf_mac_model.sv
// model: line-side mac streaming receive bytes into the data path
`timescale 1ns/1ps
module mhf_mac_model (
  input  wire logic          clock_i,
  input  wire logic          ready_i,
  output mhf_pkg::mhf_line_s line_o
);
  logic rdy_n;
  int   stalls;
  initial line_o = '0;
  always @(negedge clock_i) begin
    rdy_n = ready_i;
  end
  // n bytes counting up from b, status rides with the last byte
  task automatic send(input int n, input logic [7:0] b, input logic [31:0] st);
    int k;
    for (int i = 0; i < n; i++) begin
      line_o <= '{1'b1, i == n - 1, b + 8'(i), st};
      k = 0;
      do begin
        @(posedge clock_i);
        k++;
      end while (!rdy_n && k < 500);
      if (!rdy_n) stalls++;
    end
    line_o <= '{1'b0, 1'b0, ~line_o.data, ~st};
    @(posedge clock_i);
  endtask : send
endmodule : mhf_mac_model
